// ### rtl/pcsio_top.sv
// Servo drive control I/O for position mode with an APB register slave.
// Assumes all pins are synchronous to pclk and pulse rates far below pclk.
module pcsio_top
   import pcsio_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        ce,
   // APB slave.
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pcsio_pkg::ADDR_W-1:0] paddr,
   input  wire logic [pcsio_pkg::DATA_W-1:0] pwdata,
   output logic      [pcsio_pkg::DATA_W-1:0] prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Command pulse pins and sequence inputs.
   input  wire logic                        step_train_in,
   input  wire logic                        forward_train_in,
   input  wire logic                        error_count_clear,
   input  wire logic                        run_cmd,
   input  wire logic                        alarm_reset,
   // Encoder and fault sources.
   input  wire logic                        enc_a,
   input  wire logic                        enc_b,
   input  wire logic                        enc_z,
   input  wire logic                        fault_detect,
   // Drive outputs.
   output logic                             servo_on,
   output logic                             fault_indicator,
   output logic                             brake_hold_timing,
   output logic                             target_reached_flag,
   output logic                             index_out,
   output logic                             irq
);
   import pcsio_pkg::*;

   // Magnitude of a signed deviation value.
   function automatic logic [DEV_W-1:0] mag(input logic [DEV_W-1:0] v);
      mag = v[DEV_W-1] ? (~v + 1'b1) : v;
   endfunction

   pcsio_step_if cmd ();
   pcsio_step_if enc ();

   logic [1:0]           format_reg;
   logic [DEV_W-1:0]     window_reg;
   logic [DEV_W-1:0]     limit_reg;
   logic [EVT_W-1:0]     stat_reg;
   logic [EVT_W-1:0]     stat_next;
   logic [EVT_W-1:0]     mask_reg;
   logic [DEV_W-1:0]     dev_reg;
   logic [DEV_W-1:0]     dev_next;
   logic [DATA_W-1:0]    rdata_reg;
   logic [DATA_W-1:0]    rdata_next;
   logic                 hit;
   pcsio_state_e         state_reg;
   pcsio_state_e         state_next;
   logic [BRK_CNT_W-1:0] brk_cnt_reg;
   logic                 servo_on_reg;
   logic                 fault_ind_reg;
   logic                 brake_reg;
   logic                 reached_reg;
   logic                 index_reg;

   // Command decoder follows the selected format; encoder uses a fixed one.
   pcsio_decode u_cmd (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .line_a  (step_train_in),
      .line_b  (forward_train_in),
      .format  (format_reg),
      .step    (cmd)
   );
   pcsio_decode u_enc (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .line_a  (enc_a),
      .line_b  (enc_b),
      .format  (ENC_FORMAT),
      .step    (enc)
   );

   // Deviation update: command adds, feedback subtracts.
   wire logic [2:0]       delta = 3'(cmd.up) - 3'(cmd.down)
                                  - 3'(enc.up) + 3'(enc.down);
   wire logic [DEV_W-1:0] dev_mag = mag(dev_reg);
   wire logic             over    = mag(dev_reg) > limit_reg;
   wire logic             in_pos  = dev_mag <= window_reg;
   assign dev_next = error_count_clear ? '0
                     : dev_reg + {{(DEV_W-3){delta[2]}}, delta};

   // APB strobes and address decode.
   wire logic setup  = psel & ~penable;
   wire logic wr_en  = psel & penable & pwrite & hit & ce;
   wire logic w_ctrl = wr_en & (paddr == CTRL_OFS);
   wire logic w_win  = wr_en & (paddr == WINDOW_OFS);
   wire logic w_lim  = wr_en & (paddr == LIMIT_OFS);
   wire logic w_stat = wr_en & (paddr == IRQ_STAT_OFS);
   wire logic w_mask = wr_en & (paddr == IRQ_MASK_OFS);

   // Read selection and map hit detection.
   always_comb begin
      hit        = 1'b1;
      rdata_next = '0;
      if (paddr == CTRL_OFS) begin
         rdata_next[1:0] = format_reg;
      end else if (paddr == WINDOW_OFS) begin
         rdata_next[DEV_W-1:0] = window_reg;
      end else if (paddr == LIMIT_OFS) begin
         rdata_next[DEV_W-1:0] = limit_reg;
      end else if (paddr == STATE_OFS) begin
         rdata_next[5:0] = {brake_reg, reached_reg, fault_ind_reg, servo_on_reg,
                            state_reg};
      end else if (paddr == DEV_OFS) begin
         rdata_next[DEV_W-1:0] = dev_reg;
      end else if (paddr == IRQ_STAT_OFS) begin
         rdata_next[EVT_W-1:0] = stat_reg;
      end else if (paddr == IRQ_MASK_OFS) begin
         rdata_next[EVT_W-1:0] = mask_reg;
      end else begin
         hit = 1'b0;
      end
   end

   // Zero-wait slave; an unmapped access ends with an error.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = rdata_reg;

   // Drive sequence: run, stop, alarm latch and alarm reset.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (fault_detect || over) begin
               state_next = ST_ALARM;
            end else if (run_cmd) begin
               state_next = ST_ON;
            end
         end
         ST_ON: begin
            if (fault_detect || over) begin
               state_next = ST_ALARM;
            end else if (!run_cmd) begin
               state_next = ST_OFF;
            end
         end
         ST_ALARM: begin
            if (alarm_reset && !fault_detect && !over) begin
               state_next = ST_OFF;
            end
         end
         default: begin
            state_next = ST_ALARM;
         end
      endcase
   end

   // Events set sticky bits; a set in the clearing cycle wins.
   wire logic [EVT_W-1:0] evt = {over & (state_reg != ST_ALARM),
                                 enc_z & ~index_reg,
                                 in_pos & ~reached_reg,
                                 (state_next == ST_ALARM) & (state_reg != ST_ALARM)};
   assign stat_next = (w_stat ? (stat_reg & ~pwdata[EVT_W-1:0]) : stat_reg) | evt;
   assign irq       = |(stat_reg & mask_reg);

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         format_reg <= FMT_RST;
         window_reg <= WINDOW_RST;
         limit_reg  <= LIMIT_RST;
         mask_reg   <= MASK_RST;
      end else begin
         if (w_ctrl) format_reg <= pwdata[1:0];
         if (w_win)  window_reg <= pwdata[DEV_W-1:0];
         if (w_lim)  limit_reg  <= pwdata[DEV_W-1:0];
         if (w_mask) mask_reg   <= pwdata[EVT_W-1:0];
      end
   end

   // Read data is captured in the setup phase and shown in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= '0;
      end else if (ce && setup) begin
         rdata_reg <= rdata_next;
      end
   end

   // Deviation, state and status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_reg   <= '0;
         state_reg <= ST_OFF;
         stat_reg  <= '0;
      end else if (ce) begin
         dev_reg   <= dev_next;
         state_reg <= state_next;
         stat_reg  <= stat_next;
      end
   end

   // Brake release waits for the motor to be energised; engage is immediate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_cnt_reg <= '0;
         brake_reg   <= 1'b0;
      end else if (ce) begin
         if (state_next != ST_ON) begin
            brk_cnt_reg <= '0;
            brake_reg   <= 1'b0;
         end else if (brk_cnt_reg == BRK_CNT_W'(BRK_DLY_CYC)) begin
            brake_reg   <= 1'b1;
         end else begin
            brk_cnt_reg <= brk_cnt_reg + 1'b1;
         end
      end
   end

   // Output flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_on_reg  <= 1'b0;
         fault_ind_reg <= 1'b0;
         reached_reg   <= 1'b0;
         index_reg     <= 1'b0;
      end else if (ce) begin
         servo_on_reg  <= state_next == ST_ON;
         fault_ind_reg <= state_next != ST_ALARM;
         reached_reg   <= in_pos;
         index_reg     <= enc_z;
      end
   end

   assign servo_on            = servo_on_reg;
   assign fault_indicator     = fault_ind_reg;
   assign brake_hold_timing   = brake_reg;
   assign target_reached_flag = reached_reg;
   assign index_out           = index_reg;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Sequence, deviation and flag checks.
   sequence s_servo_start;
      ce && state_reg == ST_OFF && run_cmd && !fault_detect && !over;
   endsequence

   clr_hold_a: assert property (ce && error_count_clear |=> dev_reg == '0)
      else $error("Deviation not held at zero during clear.");
   run_on_a: assert property (s_servo_start |=> servo_on && fault_indicator)
      else $error("Run command did not turn servo on.");
   alarm_clr_a: assert property (ce && state_reg == ST_ALARM && alarm_reset &&
                                 !fault_detect && !over |=> fault_indicator)
      else $error("Alarm reset did not clear alarm.");
   index_fwd_a: assert property (ce |=> index_out == $past(enc_z))
      else $error("Index output does not follow encoder index.");
   fault_off_a: assert property (ce && fault_detect |=> !fault_indicator && !servo_on)
      else $error("Fault indicator stayed on during alarm.");
   brake_seq_a: assert property (s_servo_start ##1 (servo_on && ce)[*8] |-> !brake_hold_timing)
      else $error("Brake released before energise delay.");
   brake_off_a: assert property (!servo_on |-> !brake_hold_timing)
      else $error("Brake released while servo is off.");
   reach_win_a: assert property (ce |=> target_reached_flag ==
                                 (mag($past(dev_reg)) <= $past(window_reg)))
      else $error("Target reached flag does not match window.");
   dev_sum_a: assert property (ce && !error_count_clear && cmd.up && !cmd.down &&
                               !enc.up && !enc.down |=> dev_reg == $past(dev_reg) + 1'b1)
      else $error("Command pulse not added to deviation.");
   fb_sub_a: assert property (ce && !error_count_clear && !cmd.up && !cmd.down &&
                              enc.up && !enc.down |=> dev_reg == $past(dev_reg) - 1'b1)
      else $error("Feedback count not subtracted from deviation.");
   irq_lvl_a: assert property (irq == |(stat_reg & mask_reg))
      else $error("Interrupt level does not follow status and mask.");

   // Status bits: an event sets its bit, a written one clears it, and a set wins.
   sequence s_any_event;
      ce && evt != '0;
   endsequence

   sequence s_clear_only;
      ce && w_stat && evt == '0;
   endsequence

   idx_evt_a: assert property (ce && evt[EVT_INDEX] |=> stat_reg[EVT_INDEX])
      else $error("Index event did not set its status bit.");
   reach_evt_a: assert property (ce && in_pos && !reached_reg |=> stat_reg[EVT_REACHED])
      else $error("Target reached event did not set its status bit.");
   set_wins_a: assert property (s_any_event |=> (stat_reg & $past(evt)) == $past(evt))
      else $error("Event lost against a status clear.");
   w1c_clr_a: assert property (s_clear_only |=>
                               (stat_reg & $past(pwdata[EVT_W-1:0])) == '0)
      else $error("Written one did not clear its status bit.");

   // Alarm causes drop the fault indicator, which stays off until an alarm reset.
   sequence s_over_trip;
      ce && over && state_reg != ST_ALARM;
   endsequence

   sequence s_alarm_held;
      ce && state_reg == ST_ALARM && !alarm_reset;
   endsequence

   over_trip_a: assert property (s_over_trip |=> !fault_indicator && !servo_on)
      else $error("Deviation overflow did not raise an alarm.");
   alarm_keep_a: assert property (s_alarm_held |=> !fault_indicator && !servo_on)
      else $error("Alarm cleared without an alarm reset.");

   // Withdrawn run turns the servo off, and the brake engages in the same cycle.
   run_off_a: assert property (ce && state_reg == ST_ON && !run_cmd |=> !servo_on)
      else $error("Servo stayed on after run was withdrawn.");
   brake_eng_a: assert property (ce && state_next != ST_ON |=> !brake_hold_timing)
      else $error("Brake not engaged when servo dropped.");
   clr_ign_a: assert property (ce && error_count_clear && cmd.up |=> dev_reg == '0)
      else $error("Command pulse counted during clear.");

   // A frozen block keeps its state and ignores register writes.
   ce_hold_a: assert property (!ce |=> dev_reg == $past(dev_reg) &&
                               state_reg == $past(state_reg))
      else $error("State changed while the clock enable was low.");
   ce_wr_a: assert property (!ce && psel && penable && pwrite |=>
                             window_reg == $past(window_reg))
      else $error("Register write taken while the clock enable was low.");
   fmt_wr_a: assert property (w_ctrl |=> format_reg == $past(pwdata[1:0]))
      else $error("Format setting not taken from the write.");
endmodule

// ### rtl/pcsio_pkg.sv
// Constants shared by the pulse-command servo I/O block.
// Assumes a single 100 MHz clock domain and a 32-bit APB register bus.
package pcsio_pkg;
   // Clock rate and timing.
   localparam int         CLK_MHZ       = 100;
   localparam int         BRK_DLY_NS    = 10000;
   localparam int         BRK_DLY_CYC   = (BRK_DLY_NS * CLK_MHZ) / 1000;
   localparam int         BRK_CNT_W     = 11;
   // Widths.
   localparam int         DEV_W         = 16;
   localparam int         ADDR_W        = 8;
   localparam int         DATA_W        = 32;
   localparam int         EVT_W         = 4;
   // Command format codes.
   localparam logic [1:0] FMT_STEP_DIR  = 2'h0;
   localparam logic [1:0] FMT_REV_FWD   = 2'h1;
   localparam logic [1:0] FMT_QUAD_X1   = 2'h2;
   localparam logic [1:0] FMT_QUAD_X2   = 2'h3;
   localparam logic [1:0] ENC_FORMAT    = FMT_QUAD_X2;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] WINDOW_OFS    = 8'h04;
   localparam logic [7:0] LIMIT_OFS     = 8'h08;
   localparam logic [7:0] STATE_OFS     = 8'h0C;
   localparam logic [7:0] DEV_OFS       = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h18;
   // Reset values.
   localparam logic [1:0]  FMT_RST      = 2'h0;
   localparam logic [15:0] WINDOW_RST   = 16'h000A;
   localparam logic [15:0] LIMIT_RST    = 16'h7FFF;
   localparam logic [3:0]  MASK_RST     = 4'h0;
   // Event bit positions.
   localparam int         EVT_ALARM     = 0;
   localparam int         EVT_REACHED   = 1;
   localparam int         EVT_INDEX     = 2;
   localparam int         EVT_OVER      = 3;
   // Drive sequence states.
   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_ALARM} pcsio_state_e;
endpackage

// ### rtl/pcsio_step_if.sv
// Carrier for decoded count strobes between a pulse decoder and the top.
// Assumes both ends run on the same clock.
interface pcsio_step_if;
   logic up;
   logic down;
   modport src (output up, output down);
   modport snk (input up, input down);
endinterface

// ### rtl/pcsio_decode.sv
// Pulse-train decoder: turns two sampled pulse lines into up and down strobes.
// Assumes inputs synchronous to pclk and at most one edge per line per cycle.
module pcsio_decode
   import pcsio_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   // Pulse lines and format.
   input  wire logic       line_a,
   input  wire logic       line_b,
   input  wire logic [1:0] format,
   // Decoded strobes.
   pcsio_step_if.src       step
);
   logic a_reg;
   logic b_reg;

   // Edge detection against the previous samples.
   wire rise_a = line_a & ~a_reg;
   wire fall_a = ~line_a & a_reg;
   wire rise_b = line_b & ~b_reg;

   // Per-format direction of each counted edge.
   wire st_up  = rise_a & line_b;
   wire st_dn  = rise_a & ~line_b;
   wire q1_up  = rise_a & ~line_b;
   wire q1_dn  = rise_a & line_b;
   wire q2_up  = q1_up | (fall_a & line_b);
   wire q2_dn  = q1_dn | (fall_a & ~line_b);

   // Format selection; strobes stay low while the block is frozen.
   assign step.up   = ce & ((format == FMT_STEP_DIR) ? st_up :
                            (format == FMT_REV_FWD)  ? rise_b :
                            (format == FMT_QUAD_X1)  ? q1_up : q2_up);
   assign step.down = ce & ((format == FMT_STEP_DIR) ? st_dn :
                            (format == FMT_REV_FWD)  ? rise_a :
                            (format == FMT_QUAD_X1)  ? q1_dn : q2_dn);

   // Previous-sample registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
      end else if (ce) begin
         a_reg <= line_a;
         b_reg <= line_b;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_step_fwd;
      ce && format == FMT_STEP_DIR && !a_reg && line_a && line_b;
   endsequence
   step_dir_a: assert property (s_step_fwd |-> step.up && !step.down)
      else $error("Step format forward edge not counted up.");
   rev_fwd_a: assert property (ce && format == FMT_REV_FWD && line_a && !a_reg
                               && !(line_b && !b_reg) |-> step.down && !step.up)
      else $error("Reverse train edge not counted down.");
endmodule

// ### tb/pcsio_host_model.sv
// Host motion controller model: drives command pulses and sequence inputs.
// Assumes the drive samples these lines on rising edges of pclk.
module pcsio_host_model
   import pcsio_pkg::*;
(
   // Clock.
   input  wire logic pclk,
   // Command and sequence lines.
   output logic      step_train_in,
   output logic      forward_train_in,
   output logic      error_count_clear,
   output logic      run_cmd,
   output logic      alarm_reset
);
   timeunit 1ns;
   timeprecision 1ns;

   // Four steps of 100 cycles make a 400-cycle period, which is 250 kpps at 100 MHz.
   localparam int STEP = 100;

   // All lines idle low until the bench asks for traffic.
   initial begin
      step_train_in     = 1'b0;
      forward_train_in  = 1'b0;
      error_count_clear = 1'b0;
      run_cmd           = 1'b0;
      alarm_reset       = 1'b0;
   end

   // Waits a number of rising edges.
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Sets both pulse lines and keeps them for one step.
   task automatic put(input logic a, input logic b);
      step_train_in    <= a;
      forward_train_in <= b;
      hold(STEP);
   endtask

   // Sends n command units; a quadrature unit is one full cycle of both phases.
   task automatic move(input logic [1:0] fmt, input logic up, input int n);
      logic [7:0] pat;
      case (fmt)
         FMT_STEP_DIR: pat = {1'b0, up, 1'b1, up, 1'b0, up, 1'b0, up};
         FMT_REV_FWD:  pat = {4'h0, !up, up, 2'h0};
         default:      pat = up ? 8'hB4 : 8'h78;
      endcase
      for (int i = 0; i < n; i++) begin
         for (int k = 3; k >= 0; k--) begin
            put(pat[2*k+1], pat[2*k]);
         end
      end
   endtask

   // Holds the deviation clear long enough to be recognised.
   task automatic clear_dev();
      error_count_clear <= 1'b1;
      hold(2000);
      error_count_clear <= 1'b0;
      hold(1);
   endtask

   // Sets the run request and lets one edge pass.
   task automatic drive_run(input logic v);
      run_cmd <= v;
      hold(1);
   endtask

   // Gives a short alarm reset pulse.
   task automatic pulse_reset();
      alarm_reset <= 1'b1;
      hold(2);
      alarm_reset <= 1'b0;
      hold(1);
   endtask
endmodule

// ### tb/pulse_command_servo_io_tb_top.sv
// Bench for the servo I/O block: register access over APB and pin scenarios.
// Assumes the host model drives command and sequence pins; the bench drives the rest.
module pulse_command_servo_io_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pcsio_pkg::*;

   localparam logic [7:0] ENC_UP = 8'hB4;
   logic        pclk, presetn, ce, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err;
   logic        step_train_in, forward_train_in, error_count_clear, run_cmd, alarm_reset;
   logic        enc_a, enc_b, enc_z, fault_detect;
   logic        servo_on, fault_indicator, brake_hold_timing, target_reached_flag;
   logic        index_out, irq;
   int unsigned mismatches, compares, cycles;
   int          exp_cnt;

   pcsio_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_train_in(step_train_in), .forward_train_in(forward_train_in),
      .error_count_clear(error_count_clear), .run_cmd(run_cmd), .alarm_reset(alarm_reset),
      .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .fault_detect(fault_detect),
      .servo_on(servo_on), .fault_indicator(fault_indicator),
      .brake_hold_timing(brake_hold_timing), .target_reached_flag(target_reached_flag),
      .index_out(index_out), .irq(irq));

   pcsio_host_model host (.pclk(pclk), .step_train_in(step_train_in),
      .forward_train_in(forward_train_in), .error_count_clear(error_count_clear),
      .run_cmd(run_cmd), .alarm_reset(alarm_reset));

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Cuts a hung run short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         results();
      end
   end

   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One APB transfer; called just after a rising edge, returns one edge after release.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Turns the encoder forward by n cycles, phase A leading.
   task automatic enc_fwd(input int n);
      for (int i = 0; i < n; i++) begin
         for (int k = 3; k >= 0; k--) begin
            enc_a <= ENC_UP[2*k+1];
            enc_b <= ENC_UP[2*k];
            repeat (100) @(posedge pclk);
         end
      end
   endtask

   // Main sequence of scenarios.
   initial begin
      {presetn, psel, penable, pwrite, enc_a, enc_b, enc_z, fault_detect} = 8'h00;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("fault_ind_in_reset", 32'h0, {31'h0, fault_indicator});
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check("fault_ind_normal", 32'h1, {31'h0, fault_indicator});
      apb(1'b0, WINDOW_OFS, 32'h0);
      check("window_rst", {16'h0, WINDOW_RST}, rd);
      apb(1'b0, LIMIT_OFS, 32'h0);
      check("limit_rst", {16'h0, LIMIT_RST}, rd);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped_err", 32'h1, {31'h0, err});
      check("unmapped_data", 32'h0, rd);
      // Every format: six units forward then back; window 10 splits 6 from 12.
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, CTRL_OFS, 32'(f));
         host.move(f[1:0], 1'b1, 6);
         exp_cnt = (f == 3) ? 12 : 6;
         apb(1'b0, DEV_OFS, 32'h0);
         check("dev_fwd", 32'(exp_cnt), {16'h0, rd[15:0]});
         check("reached_fwd", {31'h0, (exp_cnt <= 10)}, {31'h0, target_reached_flag});
         host.move(f[1:0], 1'b0, 6);
         apb(1'b0, DEV_OFS, 32'h0);
         check("dev_back", 32'h0, {16'h0, rd[15:0]});
         check("reached_back", 32'h1, {31'h0, target_reached_flag});
      end
      enc_fwd(2);
      apb(1'b0, DEV_OFS, 32'h0);
      check("dev_feedback", 32'hFFFC, {16'h0, rd[15:0]});
      apb(1'b1, CTRL_OFS, 32'h0);
      // Pulses sent while the clear is held must be ignored.
      fork
         host.clear_dev();
         begin
            repeat (200) @(posedge pclk);
            host.move(FMT_STEP_DIR, 1'b1, 2);
            apb(1'b0, DEV_OFS, 32'h0);
            check("dev_held", 32'h0, {16'h0, rd[15:0]});
         end
      join
      apb(1'b0, DEV_OFS, 32'h0);
      check("dev_after_clear", 32'h0, {16'h0, rd[15:0]});
      ce <= 1'b0;
      apb(1'b1, WINDOW_OFS, 32'h5);
      ce <= 1'b1;
      apb(1'b0, WINDOW_OFS, 32'h0);
      check("window_ce_low", {16'h0, WINDOW_RST}, rd);
      host.drive_run(1'b1);
      @(negedge pclk);
      check("servo_on", 32'h1, {31'h0, servo_on});
      repeat (990) @(negedge pclk);
      check("brake_early", 32'h0, {31'h0, brake_hold_timing});
      repeat (20) @(negedge pclk);
      check("brake_release", 32'h1, {31'h0, brake_hold_timing});
      @(posedge pclk);
      enc_z <= 1'b1;
      @(posedge pclk);
      enc_z <= 1'b0;
      @(negedge pclk);
      check("index_high", 32'h1, {31'h0, index_out});
      @(negedge pclk);
      check("index_low", 32'h0, {31'h0, index_out});
      @(posedge pclk);
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      check("irq_index_stat", 32'h1, {31'h0, rd[EVT_INDEX]});
      check("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, IRQ_MASK_OFS, 32'h4);
      check("irq_unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, IRQ_STAT_OFS, 32'h4);
      check("irq_cleared", 32'h0, {31'h0, irq});
      fault_detect <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("fault_ind_alarm", 32'h0, {31'h0, fault_indicator});
      check("servo_off_alarm", 32'h0, {31'h0, servo_on});
      check("brake_engage", 32'h0, {31'h0, brake_hold_timing});
      @(posedge pclk);
      fault_detect <= 1'b0;
      host.pulse_reset();
      @(negedge pclk);
      check("fault_ind_reset", 32'h1, {31'h0, fault_indicator});
      @(posedge pclk);
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      check("irq_alarm_stat", 32'h1, {31'h0, rd[EVT_ALARM]});
      // A zero limit turns one forward step into an overflow alarm.
      apb(1'b1, LIMIT_OFS, 32'h0);
      host.move(FMT_STEP_DIR, 1'b1, 1);
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      check("irq_over_stat", 32'h1, {31'h0, rd[EVT_OVER]});
      check("fault_ind_over", 32'h0, {31'h0, fault_indicator});
      results();
   end
endmodule
